// >>> hw/branch_condition_pkg.sv
package branch_condition_pkg;

  // widths: singleword 36 bits, address space 2^29 singlewords
  localparam int QUARTER_W = 9;
  localparam int HALF_W    = 18;
  localparam int SINGLE_W  = 36;
  localparam int DOUBLE_W  = 72;
  localparam int PC_W      = 29;
  localparam int SKIP_W    = 4;

  // skip offset range in singlewords
  localparam int SKIP_MIN = -8;
  localparam int SKIP_MAX = 7;

  // result latency of the datapath in cycles
  localparam int LATENCY = 2;

  typedef enum logic [3:0] {
    greater_than          = 4'h0,
    equal_to              = 4'h1,
    greater_or_equal      = 4'h2,
    less_than             = 4'h3,
    not_equal             = 4'h4,
    less_or_equal         = 4'h5,
    zero_masked_bits      = 4'h6,
    every_masked_bit_one  = 4'h7,
    any_masked_bit_one    = 4'h8,
    some_masked_bit_clear = 4'h9
  } combined_condition_type;

  typedef enum logic [1:0] {
    width_quarter = 2'h0,
    width_half    = 2'h1,
    width_single  = 2'h2,
    width_double  = 2'h3
  } width_sel_type;

  typedef enum logic [3:0] {
    short_branch_cond        = 4'h0,
    incr_short_branch        = 4'h1,
    decr_short_branch        = 4'h2,
    long_branch_cond         = 4'h3,
    long_branch_vs_zero      = 4'h4,
    long_branch_uncond       = 4'h5,
    incr_long_branch         = 4'h6,
    incr_long_branch_vs_zero = 4'h7,
    incr_branch_uncond       = 4'h8,
    decr_long_branch         = 4'h9
  } branch_op_type;

endpackage

// >>> hw/count_adjust.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// registered counter step with signed overflow detect
// ----------------------------------------------------------------
module count_adjust (
  input  wire logic                                       sys_clk,
  input  wire logic                                       reset,
  input  wire logic                                       stepEnable,
  input  wire logic                                       stepDown,
  input  wire logic [branch_condition_pkg::SINGLE_W-1:0] countIn,
  output logic      [branch_condition_pkg::SINGLE_W-1:0] countOut,
  output logic                                            overflowOut
);
  import branch_condition_pkg::*;

  typedef struct packed {
    logic [SINGLE_W-1:0] count;
    logic                ovf;
  } adjust_state_type;

  adjust_state_type state_q;
  adjust_state_type state_d;

  always_comb begin
    state_d = state_q;
    state_d.count = countIn;
    state_d.ovf   = 1'b0;
    if (stepEnable) begin
      if (stepDown) begin
        state_d.count = countIn - {{(SINGLE_W-1){1'b0}}, 1'b1};
        // wrap from most negative to most positive
        state_d.ovf = countIn[SINGLE_W-1] & ~state_d.count[SINGLE_W-1];
      end else begin
        state_d.count = countIn + {{(SINGLE_W-1){1'b0}}, 1'b1};
        // wrap from most positive to most negative
        state_d.ovf = ~countIn[SINGLE_W-1] & state_d.count[SINGLE_W-1];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign countOut    = state_q.count;
  assign overflowOut = state_q.ovf;

endmodule

// >>> hw/branch_condition_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - six signed arithmetic conditions selected by the instruction modifier
// - zero masked bits: first AND mask equals zero
// - every masked bit one: inverted first AND mask equals zero
// - any masked bit one: first AND mask is nonzero
// - some masked bit clear: inverted first AND mask is nonzero
// - jumps reach the whole address space; skips only a short range
// - conditional skip tests all ten conditions, target offset -8..7
// - conditional skip operands use quarter, half, single or double width
// - false condition continues with the next sequential instruction
// - increment-and-skip adds one, keeps carry, compares, short skip
// - increments may set the integer overflow flag
// - decrement-and-skip subtracts one, keeps carry, compares, short skip
// - decrements may set the integer overflow flag
// - increment and decrement skips use singleword operands
// - conditional long jump compares first half against second half
// - jump-vs-zero compares operand against zero at selected width
// - unconditional jump always goes to its resolved destination
// - increment long jump bumps first half, compares with second half
// - increment jump-vs-zero bumps singleword then compares against zero
// - increment jump-always bumps singleword then always jumps
// - decrement long jump drops first half, compares with second half
module branch_condition_unit (
  input  wire logic                                         sys_clk,
  input  wire logic                                         reset,
  input  wire logic                                         opValid,
  input  wire branch_condition_pkg::branch_op_type          branchOp,
  input  wire branch_condition_pkg::combined_condition_type combinedCondition,
  input  wire branch_condition_pkg::width_sel_type          widthSel,
  input  wire logic [branch_condition_pkg::DOUBLE_W-1:0]   firstOperand,
  input  wire logic [branch_condition_pkg::DOUBLE_W-1:0]   secondOperand,
  input  wire logic [branch_condition_pkg::PC_W-1:0]       currentPc,
  input  wire logic [branch_condition_pkg::PC_W-1:0]       nextPc,
  input  wire logic [branch_condition_pkg::SKIP_W-1:0]     skipOffset,
  input  wire logic [branch_condition_pkg::PC_W-1:0]       branchTarget,
  output logic                                              resultValid,
  output logic                                              branchTaken,
  output logic      [branch_condition_pkg::PC_W-1:0]       newPc,
  output logic                                              counterWrite,
  output logic      [branch_condition_pkg::SINGLE_W-1:0]   counterValue,
  output logic                                              integerOverflowFlag
);
  import branch_condition_pkg::*;

  // ----------------------------------------------------------------
  // condition evaluation
  // ----------------------------------------------------------------
  // arithmetic part on a sign-extended pair of operands
  function automatic logic arith_condition(input combined_condition_type c,
                                           input logic signed [DOUBLE_W-1:0] a,
                                           input logic signed [DOUBLE_W-1:0] b);
    logic r;
    r = 1'b0;
    case (c)
      greater_than:     r = a > b;
      equal_to:         r = a == b;
      greater_or_equal: r = a >= b;
      less_than:        r = a < b;
      not_equal:        r = a != b;
      less_or_equal:    r = a <= b;
      default:          r = 1'b0;
    endcase
    return r;
  endfunction

  // mask tests on sign-extended operands agree with the narrow test:
  // any upper bit that survives the and also survives at the narrow top bit
  function automatic logic mask_condition(input combined_condition_type c,
                                          input logic [DOUBLE_W-1:0] a,
                                          input logic [DOUBLE_W-1:0] m);
    logic r;
    r = 1'b0;
    case (c)
      zero_masked_bits:      r = ((a & m) == '0);
      every_masked_bit_one:  r = ((~a & m) == '0);
      any_masked_bit_one:    r = ((a & m) != '0);
      some_masked_bit_clear: r = ((~a & m) != '0);
      default:               r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic combined_condition(input combined_condition_type c,
                                              input logic [DOUBLE_W-1:0] a,
                                              input logic [DOUBLE_W-1:0] b);
    logic r;
    r = 1'b0;
    case (c)
      greater_than, equal_to, greater_or_equal,
      less_than, not_equal, less_or_equal: r = arith_condition(c, a, b);
      zero_masked_bits, every_masked_bit_one,
      any_masked_bit_one, some_masked_bit_clear: r = mask_condition(c, a, b);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // sign extension to the full compare width at the selected precision
  function automatic logic [DOUBLE_W-1:0] size_operand(input width_sel_type w,
                                                       input logic [DOUBLE_W-1:0] v);
    logic [DOUBLE_W-1:0] r;
    r = v;
    case (w)
      width_quarter: r = {{(DOUBLE_W-QUARTER_W){v[QUARTER_W-1]}}, v[QUARTER_W-1:0]};
      width_half:    r = {{(DOUBLE_W-HALF_W){v[HALF_W-1]}}, v[HALF_W-1:0]};
      width_single:  r = {{(DOUBLE_W-SINGLE_W){v[SINGLE_W-1]}}, v[SINGLE_W-1:0]};
      width_double:  r = v;
      default:       r = v;
    endcase
    return r;
  endfunction

  function automatic logic [DOUBLE_W-1:0] widen_single(input logic [SINGLE_W-1:0] v);
    return {{(DOUBLE_W-SINGLE_W){v[SINGLE_W-1]}}, v};
  endfunction

  // skip forms branch relative to the current pc
  function automatic logic short_op_format(input branch_op_type o);
    logic r;
    r = 1'b0;
    case (o)
      short_branch_cond, incr_short_branch, decr_short_branch: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   stage1Valid;
    branch_op_type          op;
    combined_condition_type cond;
    width_sel_type          width;
    logic [DOUBLE_W-1:0]    opA;
    logic [DOUBLE_W-1:0]    opB;
    logic [PC_W-1:0]        shortTarget;
    logic [PC_W-1:0]        longTarget;
    logic [PC_W-1:0]        seqPc;
    logic                   outValid;
    logic                   outTaken;
    logic [PC_W-1:0]        outPc;
    logic                   outCntWrite;
    logic [SINGLE_W-1:0]    outCnt;
    logic                   outOvf;
  } unit_state_type;

  unit_state_type state_q;
  unit_state_type state_d;

  logic                stepEnable;
  logic                stepDown;
  logic [SINGLE_W-1:0] stepIn;
  logic [SINGLE_W-1:0] stepOut;
  logic                stepOvf;

  // counter half of the first operand feeds the stepper in stage 0
  always_comb begin
    stepEnable = 1'b0;
    stepDown   = 1'b0;
    stepIn     = firstOperand[SINGLE_W-1:0];
    if (opValid) begin
      case (branchOp)
        incr_short_branch, incr_long_branch_vs_zero,
        incr_branch_uncond: stepEnable = 1'b1;
        incr_long_branch:   stepEnable = 1'b1;
        decr_short_branch: begin
          stepEnable = 1'b1;
          stepDown   = 1'b1;
        end
        decr_long_branch: begin
          stepEnable = 1'b1;
          stepDown   = 1'b1;
        end
        default: stepEnable = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // counter step
  // ----------------------------------------------------------------
  // the stepper registers its result, so stage 1 compares the stepped
  // counter of the op that sits in stage 1
  count_adjust stepper (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .stepEnable  (stepEnable),
    .stepDown    (stepDown),
    .countIn     (stepIn),
    .countOut    (stepOut),
    .overflowOut (stepOvf)
  );

  // ----------------------------------------------------------------
  // two stage pipeline
  // ----------------------------------------------------------------
  always_comb begin
    logic                stepped;
    logic [DOUBLE_W-1:0] lhs;
    logic [DOUBLE_W-1:0] rhs;
    logic                taken;
    stepped = 1'b0;
    lhs     = '0;
    rhs     = '0;
    taken   = 1'b0;
    state_d = state_q;

    // stage 0: capture operands and targets
    state_d.stage1Valid = opValid;
    state_d.op          = branchOp;
    state_d.cond        = combinedCondition;
    state_d.width       = widthSel;
    state_d.opA         = firstOperand;
    state_d.opB         = secondOperand;
    // signed short offset, wraps inside the address space
    state_d.shortTarget = currentPc + {{(PC_W-SKIP_W){skipOffset[SKIP_W-1]}}, skipOffset};
    state_d.longTarget  = branchTarget;
    state_d.seqPc       = nextPc;

    // stage 1: compare using the stepped counter where one applies
    case (state_q.op)
      short_branch_cond: begin
        lhs   = size_operand(state_q.width, state_q.opA);
        rhs   = size_operand(state_q.width, state_q.opB);
        taken = combined_condition(state_q.cond, lhs, rhs);
      end
      incr_short_branch, decr_short_branch: begin
        stepped = 1'b1;
        lhs   = widen_single(stepOut);
        rhs   = widen_single(state_q.opB[SINGLE_W-1:0]);
        taken = arith_condition(state_q.cond, lhs, rhs);
      end
      long_branch_cond: begin
        lhs   = widen_single(state_q.opA[SINGLE_W-1:0]);
        rhs   = widen_single(state_q.opA[DOUBLE_W-1:SINGLE_W]);
        taken = arith_condition(state_q.cond, lhs, rhs);
      end
      incr_long_branch, decr_long_branch: begin
        stepped = 1'b1;
        lhs   = widen_single(stepOut);
        rhs   = widen_single(state_q.opA[DOUBLE_W-1:SINGLE_W]);
        taken = arith_condition(state_q.cond, lhs, rhs);
      end
      long_branch_vs_zero: begin
        lhs   = size_operand(state_q.width, state_q.opA);
        taken = arith_condition(state_q.cond, lhs, '0);
      end
      incr_long_branch_vs_zero: begin
        stepped = 1'b1;
        lhs   = widen_single(stepOut);
        taken = arith_condition(state_q.cond, lhs, '0);
      end
      incr_branch_uncond: begin
        stepped = 1'b1;
        taken   = 1'b1;
      end
      long_branch_uncond: taken = 1'b1;
      default: taken = 1'b0;
    endcase

    state_d.outValid    = state_q.stage1Valid;
    state_d.outTaken    = state_q.stage1Valid & taken;
    if (!state_q.stage1Valid) begin
      state_d.outPc = state_q.outPc;
    end else if (!taken) begin
      state_d.outPc = state_q.seqPc;
    end else if (short_op_format(state_q.op)) begin
      state_d.outPc = state_q.shortTarget;
    end else begin
      state_d.outPc = state_q.longTarget;
    end
    // write back whether or not the branch is taken; carry is not touched
    state_d.outCntWrite = state_q.stage1Valid & stepped;
    state_d.outCnt      = stepped ? stepOut : state_q.outCnt;
    state_d.outOvf      = state_q.stage1Valid & stepped & stepOvf;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign resultValid         = state_q.outValid;
  assign branchTaken         = state_q.outTaken;
  assign newPc               = state_q.outPc;
  assign counterWrite        = state_q.outCntWrite;
  assign counterValue        = state_q.outCnt;
  assign integerOverflowFlag = state_q.outOvf;

endmodule

// >>> bench/branch_condition_checker.sv
`timescale 1ns/1ps
// ------
// port checks of the branch unit
// ------
module branch_condition_checker
  import branch_condition_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   reset,
  input wire logic                   opValid,
  input wire branch_op_type          branchOp,
  input wire combined_condition_type combinedCondition,
  input wire width_sel_type          widthSel,
  input wire logic [DOUBLE_W-1:0]    firstOperand,
  input wire logic [DOUBLE_W-1:0]    secondOperand,
  input wire logic [PC_W-1:0]        currentPc,
  input wire logic [PC_W-1:0]        nextPc,
  input wire logic [SKIP_W-1:0]      skipOffset,
  input wire logic [PC_W-1:0]        branchTarget,
  input wire logic                   resultValid,
  input wire logic                   branchTaken,
  input wire logic [PC_W-1:0]        newPc,
  input wire logic                   counterWrite,
  input wire logic [SINGLE_W-1:0]    counterValue,
  input wire logic                   integerOverflowFlag
);
  logic                incrOp;
  logic                decrOp;
  logic                stepOp;
  logic                wrapIn;
  logic [SINGLE_W-1:0] countIn;
  logic [PC_W-1:0]     skipTarget;
  assign countIn = firstOperand[SINGLE_W-1:0];
  assign incrOp = branchOp inside {incr_short_branch, incr_long_branch,
                                   incr_long_branch_vs_zero, incr_branch_uncond};
  assign decrOp = branchOp inside {decr_short_branch, decr_long_branch};
  assign stepOp = incrOp || decrOp;
  assign wrapIn = (incrOp && countIn == 36'h7ffffffff) || (decrOp && countIn == 36'h800000000);
  assign skipTarget = currentPc + {{(PC_W-SKIP_W){skipOffset[SKIP_W-1]}}, skipOffset};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_result_latency: assert property (opValid |-> ##2 resultValid)
    else $error("no result two cycles after an op");
  a_fall_through:
    assert property (resultValid && !branchTaken |-> newPc == $past(nextPc, 2))
    else $error("untaken branch left the sequential path");
  a_uncond_jump:
    assert property (opValid && branchOp inside {long_branch_uncond, incr_branch_uncond}
      |-> ##2 branchTaken && newPc == $past(branchTarget, 2))
    else $error("unconditional jump not taken to its target");
  a_short_target:
    assert property (opValid && branchOp inside {short_branch_cond, incr_short_branch,
      decr_short_branch} ##2 branchTaken |-> newPc == $past(skipTarget, 2))
    else $error("skip target is not pc plus offset");
  a_step_write: assert property (opValid |-> ##2 counterWrite == $past(stepOp, 2))
    else $error("counter write-back wrong");
  a_incr_value:
    assert property (opValid && incrOp |-> ##2 counterValue == $past(countIn, 2) + 36'h1)
    else $error("incremented counter wrong");
  a_decr_value:
    assert property (opValid && decrOp |-> ##2 counterValue == $past(countIn, 2) - 36'h1)
    else $error("decremented counter wrong");
  a_wrap_flag:
    assert property (opValid |-> ##2 integerOverflowFlag == $past(wrapIn, 2))
    else $error("overflow flag wrong");
  a_mask_refused:
    assert property (opValid && combinedCondition > less_or_equal && !(branchOp inside
      {short_branch_cond, long_branch_uncond, incr_branch_uncond}) |-> ##2 !branchTaken)
    else $error("mask condition taken outside the skip");
endmodule

bind branch_condition_unit branch_condition_checker checker_i (
  .sys_clk(sys_clk), .reset(reset), .opValid(opValid), .branchOp(branchOp),
  .combinedCondition(combinedCondition), .widthSel(widthSel),
  .firstOperand(firstOperand), .secondOperand(secondOperand), .currentPc(currentPc),
  .nextPc(nextPc), .skipOffset(skipOffset), .branchTarget(branchTarget),
  .resultValid(resultValid), .branchTaken(branchTaken), .newPc(newPc),
  .counterWrite(counterWrite), .counterValue(counterValue),
  .integerOverflowFlag(integerOverflowFlag));

// >>> bench/pc_update_model.sv
`timescale 1ns/1ps
// ------
// program counter and counter write-back
// ------
module pc_update_model
  import branch_condition_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                resultValid,
  input  wire logic [PC_W-1:0]     newPc,
  input  wire logic                counterWrite,
  input  wire logic [SINGLE_W-1:0] counterValue,
  output logic      [PC_W-1:0]     pc_q,
  output logic      [SINGLE_W-1:0] counter_q
);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pc_q <= '0;
      counter_q <= '0;
    end else begin
      if (resultValid) pc_q <= newPc;
      if (counterWrite) counter_q <= counterValue;
    end
  end
endmodule

// >>> bench/branch_condition_unit_tb.sv
`timescale 1ns/1ps
module branch_condition_unit_tb;
  import branch_condition_pkg::*;
  typedef struct {
    branch_op_type          op;
    combined_condition_type cond;
    width_sel_type          wsel;
    logic [DOUBLE_W-1:0]    a, b;
    logic [PC_W-1:0]        cur, tgt, pc;
    logic [SKIP_W-1:0]      off;
    logic                   taken, cw, ovf;
    logic [SINGLE_W-1:0]    cv;
  } row_type;
  logic                   sys_clk = 1'b0;
  logic                   reset = 1'b1;
  logic                   opValid = 1'b0;
  branch_op_type          branchOp = short_branch_cond;
  combined_condition_type combinedCondition = greater_than;
  width_sel_type          widthSel = width_quarter;
  logic [DOUBLE_W-1:0]    firstOperand = '0;
  logic [DOUBLE_W-1:0]    secondOperand = '0;
  logic [PC_W-1:0]        currentPc = '0;
  logic [PC_W-1:0]        nextPc = '0;
  logic [SKIP_W-1:0]      skipOffset = '0;
  logic [PC_W-1:0]        branchTarget = '0;
  logic                   resultValid, branchTaken, counterWrite, integerOverflowFlag;
  logic [PC_W-1:0]        newPc, savedPc;
  logic [SINGLE_W-1:0]    counterValue, savedCount;
  row_type                rows [100];
  row_type                expq [$];
  row_type                want;
  int                     failures = 0;
  int                     samplesChecked = 0;
  int                     cycles = 0;
  logic [SINGLE_W-1:0]    pat [4] = '{36'h7ffffffff, 36'h800000000, 36'h5, 36'hfffffffff};

  always #4 sys_clk = ~sys_clk;

  branch_condition_unit dut (.sys_clk(sys_clk), .reset(reset), .opValid(opValid),
    .branchOp(branchOp), .combinedCondition(combinedCondition), .widthSel(widthSel),
    .firstOperand(firstOperand), .secondOperand(secondOperand), .currentPc(currentPc),
    .nextPc(nextPc), .skipOffset(skipOffset), .branchTarget(branchTarget),
    .resultValid(resultValid), .branchTaken(branchTaken), .newPc(newPc),
    .counterWrite(counterWrite), .counterValue(counterValue),
    .integerOverflowFlag(integerOverflowFlag));
  pc_update_model partner (.sys_clk(sys_clk), .reset(reset), .resultValid(resultValid),
    .newPc(newPc), .counterWrite(counterWrite), .counterValue(counterValue),
    .pc_q(savedPc), .counter_q(savedCount));

  function automatic logic signed [DOUBLE_W-1:0] sext(logic [DOUBLE_W-1:0] v, width_sel_type w);
    int s;
    s = DOUBLE_W - (QUARTER_W << w);
    return $signed(v << s) >>> s;
  endfunction

  function automatic row_type predict(row_type r);
    logic signed [DOUBLE_W-1:0] x, y;
    logic                       dec, hit;
    dec = r.op inside {decr_short_branch, decr_long_branch};
    r.cw = dec || r.op inside {incr_short_branch, incr_long_branch,
                               incr_long_branch_vs_zero, incr_branch_uncond};
    r.cv = dec ? r.a[SINGLE_W-1:0] - 36'h1 : r.a[SINGLE_W-1:0] + 36'h1;
    r.ovf = r.cw && r.cv == (dec ? 36'h7ffffffff : 36'h800000000);
    x = sext(r.cw ? DOUBLE_W'(r.cv) : r.a,
             r.op inside {short_branch_cond, long_branch_vs_zero} ? r.wsel : width_single);
    y = 0;
    if (r.op == short_branch_cond) y = sext(r.b, r.wsel);
    if (r.op inside {incr_short_branch, decr_short_branch}) y = sext(r.b, width_single);
    if (r.op inside {long_branch_cond, incr_long_branch, decr_long_branch})
      y = sext(r.a >> SINGLE_W, width_single);
    case (r.cond)
      greater_than:         hit = x > y;
      equal_to:             hit = x == y;
      greater_or_equal:     hit = x >= y;
      less_than:            hit = x < y;
      not_equal:            hit = x != y;
      less_or_equal:        hit = x <= y;
      zero_masked_bits:     hit = (x & y) == 0;
      every_masked_bit_one: hit = (~x & y) == 0;
      any_masked_bit_one:   hit = (x & y) != 0;
      default:              hit = (~x & y) != 0;
    endcase
    if (r.cond > less_or_equal && r.op != short_branch_cond) hit = 1'b0;
    if (r.op inside {long_branch_uncond, incr_branch_uncond}) hit = 1'b1;
    r.taken = hit;
    r.pc = !hit ? r.cur + 29'h1 : r.op inside {short_branch_cond, incr_short_branch,
      decr_short_branch} ? r.cur + {{(PC_W-SKIP_W){r.off[SKIP_W-1]}}, r.off} : r.tgt;
    return r;
  endfunction

  task automatic check_value(logic [SINGLE_W-1:0] got, logic [SINGLE_W-1:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic issue(row_type r);
    @(posedge sys_clk);
    opValid           <= 1'b1;
    branchOp          <= r.op;
    combinedCondition <= r.cond;
    widthSel          <= r.wsel;
    firstOperand      <= r.a;
    secondOperand     <= r.b;
    currentPc         <= r.cur;
    nextPc            <= r.cur + 29'h1;
    skipOffset        <= r.off;
    branchTarget      <= r.tgt;
    expq.push_back(r);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end

  // ------
  // result scoreboard
  // ------
  always @(posedge sys_clk) begin
    if (!reset && resultValid === 1'b1) begin
      if (expq.size() == 0) begin
        check_value(SINGLE_W'(resultValid), '0);
      end else begin
        want = expq.pop_front();
        check_value(SINGLE_W'(branchTaken), SINGLE_W'(want.taken));
        check_value(SINGLE_W'(newPc), SINGLE_W'(want.pc));
        check_value(SINGLE_W'(counterWrite), SINGLE_W'(want.cw));
        check_value(SINGLE_W'(integerOverflowFlag), SINGLE_W'(want.ovf));
        if (want.cw)
          check_value(counterValue, want.cv);
      end
    end
  end

  initial begin
    for (int n = 0; n < 100; n++) begin
      rows[n].op = branch_op_type'(n / 10);
      rows[n].cond = combined_condition_type'(n % 10);
      rows[n].wsel = width_sel_type'(n % 4);
      rows[n].a = {pat[(n + 1) % 4], pat[n % 4]};
      rows[n].b = {pat[n % 3], pat[(n / 3) % 4]};
      rows[n].cur = 29'h1ffffffa + PC_W'(n);
      rows[n].tgt = 29'h0abcd000 + PC_W'(n);
      rows[n].off = SKIP_W'(n);
      rows[n] = predict(rows[n]);
    end
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[n]) issue(rows[n]);
    @(posedge sys_clk);
    opValid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check_value(SINGLE_W'(savedPc), SINGLE_W'(rows[99].pc));
    check_value(savedCount, rows[99].cv);
    // reset in mid-flight drops the op and clears every output
    issue(rows[35]);
    @(posedge sys_clk);
    opValid <= 1'b0;
    reset <= 1'b1;
    @(posedge sys_clk);
    #1;
    expq.delete();
    check_value(SINGLE_W'({resultValid, branchTaken, counterWrite, integerOverflowFlag}), '0);
    check_value(SINGLE_W'(newPc), '0);
    check_value(counterValue, '0);
    @(posedge sys_clk);
    reset <= 1'b0;
    issue(rows[68]);
    issue(rows[50]);
    @(posedge sys_clk);
    opValid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check_value(SINGLE_W'(expq.size()), '0);
    finish_test();
  end
endmodule
